/* File: verilog/usbp_line_ctrl.sv */
// Port line control registers for two USB protocol engines, two ports
// each. Assumes processor and parallel host port strobes are
// synchronous to clk_sys; line inputs are already resolved levels.
`timescale 1ns/10ps
module usbp_line_ctrl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Internal processor access
   input wire usbp_pkg::usbp_bus_t cpuBus,
   output logic [15:0] cpuRdata,
   // Parallel host port access
   input wire usbp_pkg::usbp_bus_t hostPortBus,
   output logic [15:0] hostPortRdata,
   // Engine side, index is engine; sofEopEn index is engine*2 + port
   input wire logic [1:0] portSel,
   input wire usbp_pkg::usbp_line_t [1:0] txLine,
   input wire logic [1:0] txEn,
   output usbp_pkg::usbp_line_t [1:0] rxLine,
   output logic [1:0] hostMode,
   output logic [1:0] activeLowSpeed,
   output logic [1:0] xcvrPowerDown,
   output logic [3:0] sofEopEn,
   // Port pins, index is engine*2 + port (0 = A)
   input wire usbp_pkg::usbp_line_t [3:0] pinIn,
   output usbp_pkg::usbp_pin_t [3:0] pinOut
);
   import usbp_pkg::*;

   logic [1:0] rstSync;
   wire logic rstN;
   logic [11:0] ctrl [USBP_NUM_ENG];
   logic [11:0] next_ctrl [USBP_NUM_ENG];
   wire logic [15:0] readVal [USBP_NUM_ENG];
   wire logic [1:0] cpuHit;
   wire logic [1:0] hostPortHit;
   wire usbp_pin_t [3:0] next_pin;
   wire logic [3:0] next_sof;
   wire usbp_line_t [1:0] next_rx;
   wire logic [15:0] next_cpuRdata;
   wire logic [15:0] next_hostPortRdata;

   function automatic logic [1:0] engHit(input logic [15:0] a);
      engHit = {a == USBP_ADDR_ENG2, a == USBP_ADDR_ENG1};
   endfunction

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) rstSync <= 2'b00;
      else rstSync <= {rstSync[0], 1'b1};
   end
   assign rstN = rstSync[1];

   assign cpuHit = engHit(cpuBus.addr);
   assign hostPortHit = engHit(hostPortBus.addr);

   genvar e;
   generate
      for (e = 0; e < USBP_NUM_ENG; e++) begin : g_eng
         // host port wins a same-cycle write clash
         always_comb begin
            next_ctrl[e] = ctrl[e];
            if (hostPortBus.wr && hostPortHit[e])
               next_ctrl[e] = hostPortBus.wdata[USBP_CTRL_HI:0];
            else if (cpuBus.wr && cpuHit[e])
               next_ctrl[e] = cpuBus.wdata[USBP_CTRL_HI:0];
         end
         always_ff @(posedge clk_sys or negedge rstN) begin
            if (!rstN) ctrl[e] <= USBP_CTRL_RESET;
            else ctrl[e] <= next_ctrl[e];
         end
         // status bits read straight from the lines
         assign readVal[e] = {pinIn[2*e+1].dp, pinIn[2*e+1].dm,
                              pinIn[2*e].dp, pinIn[2*e].dm, ctrl[e]};
         assign next_rx[e] = ctrl[e][USBP_BIT_SUSP] ? usbp_line_t'(2'b00)
                             : pinIn[2*e + int'(portSel[e])];
         assign hostMode[e] = ctrl[e][USBP_BIT_HOST];
         assign xcvrPowerDown[e] = ctrl[e][USBP_BIT_SUSP];
         assign activeLowSpeed[e] = portSel[e]
            ? ctrl[e][USBP_BIT_SPD_A + 1] : ctrl[e][USBP_BIT_SPD_A];
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < USBP_NUM_ENG * USBP_NUM_PORT; i++) begin : g_port
         localparam int E = i / USBP_NUM_PORT;
         localparam int P = i % USBP_NUM_PORT;
         wire logic act;
         // either role transmits engine data only on the selected port; forcing ignores the selection
         assign act = (int'(portSel[E]) == P);
         usbp_port_drive u_drive (
            .resEn(ctrl[E][USBP_BIT_RES_A + P]),
            // role bit steers the pull resistors
            .hostMode(ctrl[E][USBP_BIT_HOST]),
            .lowSpeed(ctrl[E][USBP_BIT_SPD_A + P]),
            .force_(usbp_force_t'(ctrl[E][USBP_BIT_FRC_A+2*P +: 2])),
            .suspend(ctrl[E][USBP_BIT_SUSP]),
            .active(act),
            .txLine(txLine[E]),
            .txEn(txEn[E]),
            .pin(next_pin[i])
         );
         // markers gated by host role and active port
         assign next_sof[i] = ctrl[E][USBP_BIT_HOST] && act
                              && ctrl[E][USBP_BIT_SOF_A + P];
      end
   endgenerate

   // either master reads both copies; unmapped reads zero
   assign next_cpuRdata = cpuHit[0] ? readVal[0]
                        : cpuHit[1] ? readVal[1] : USBP_RD_NONE;
   assign next_hostPortRdata = hostPortHit[0] ? readVal[0]
                             : hostPortHit[1] ? readVal[1] : USBP_RD_NONE;

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         cpuRdata <= USBP_RD_NONE;
         hostPortRdata <= USBP_RD_NONE;
         pinOut <= '0;
         sofEopEn <= '0;
         rxLine <= '0;
      end else begin
         if (cpuBus.rd) cpuRdata <= next_cpuRdata;
         if (hostPortBus.rd) hostPortRdata <= next_hostPortRdata;
         pinOut <= next_pin;
         sofEopEn <= next_sof;
         rxLine <= next_rx;
      end
   end

   chk_reset_clears: assert property (
      @(posedge clk_sys) $rose(rstN) |->
      ctrl[0] == USBP_CTRL_RESET && ctrl[1] == USBP_CTRL_RESET)
      else $error("control not clear after reset");
   // processor write lands in engine 2 copy
   chk_cpu_write: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      cpuBus.wr && cpuHit[1] && !hostPortBus.wr |=>
      ctrl[1] == $past(cpuBus.wdata[USBP_CTRL_HI:0]))
      else $error("processor write lost");
   // same-cycle clash keeps the host port word
   chk_write_clash: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      cpuBus.wr && hostPortBus.wr && cpuHit[1] && hostPortHit[1] |=>
      ctrl[1] == $past(hostPortBus.wdata[USBP_CTRL_HI:0]))
      else $error("write clash resolved wrongly");
   // host port read returns the copy
   chk_host_port_read: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      hostPortBus.rd && hostPortHit[0] |=>
      hostPortRdata == $past(readVal[0]))
      else $error("host port read mismatch");
   chk_status_live: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      cpuBus.rd && cpuHit[0] |=> cpuRdata[15:USBP_STATUS_LO] ==
      $past({pinIn[1].dp, pinIn[1].dm, pinIn[0].dp, pinIn[0].dm}))
      else $error("line status wrong");
   chk_host_pulldn: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      ctrl[0][USBP_BIT_RES_A] && ctrl[0][USBP_BIT_HOST] |=>
      pinOut[0].dpPullDn && pinOut[0].dmPullDn && !pinOut[0].dpPullUp)
      else $error("host pull-downs missing");
   // low-speed device pull-up on minus line
   chk_dev_pullup: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      ctrl[0][USBP_BIT_RES_A] && !ctrl[0][USBP_BIT_HOST] &&
      ctrl[0][USBP_BIT_SPD_A] |=>
      pinOut[0].dmPullUp && !pinOut[0].dpPullUp && !pinOut[0].dpPullDn)
      else $error("device pull-up wrong");
   // full-speed device pull-up on plus line
   chk_dev_pullup_fs: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      ctrl[0][USBP_BIT_RES_A] && !ctrl[0][USBP_BIT_HOST] &&
      !ctrl[0][USBP_BIT_SPD_A] |=>
      pinOut[0].dpPullUp && !pinOut[0].dmPullUp && !pinOut[0].dmPullDn)
      else $error("full-speed pull-up wrong");
   chk_res_off: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      !ctrl[1][USBP_BIT_RES_A + 1] |=> pinOut[3][3:0] == 4'h0)
      else $error("pull active while disabled");
   // SE0 forced on port B even when unselected
   chk_force_se0: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      ctrl[0][USBP_BIT_FRC_A + 2 +: 2] == USBP_FRC_SE0 |=>
      pinOut[1].dpOe && pinOut[1].dmOe &&
      !pinOut[1].dpOut && !pinOut[1].dmOut)
      else $error("forced SE0 missing");
   // suspended engine with no port forced neither sends nor receives
   chk_suspend_quiet: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      ctrl[0][USBP_BIT_SUSP] && ctrl[0][USBP_BIT_FRC_A +: 4] == 4'h0 |=>
      rxLine[0] == 2'b00 && !pinOut[0].dpOe && !pinOut[1].dpOe)
      else $error("transceiver active in suspend");
   // no frame markers in device role
   chk_sof_gate: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      !ctrl[1][USBP_BIT_HOST] |=> sofEopEn[3:2] == 2'b00)
      else $error("marker enabled in device role");
   // host role marks the active port only
   chk_sof_host: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      ctrl[0][USBP_BIT_HOST] && portSel[0] |=>
      sofEopEn[1:0] == {$past(ctrl[0][USBP_BIT_SOF_A + 1]), 1'b0})
      else $error("marker on wrong port");
   // receive path follows the selected port
   chk_port_sel: assert property (
      @(posedge clk_sys) disable iff (!rstN)
      !ctrl[0][USBP_BIT_SUSP] |=>
      rxLine[0] == $past(portSel[0] ? pinIn[1] : pinIn[0]))
      else $error("receive port select wrong");
endmodule

/* File: verilog/usbp_pkg.sv */
// Constants, codes and carriers for the USB port line control block.
// Assumes a 16-bit register space shared by the internal processor and
// the parallel host port.
package usbp_pkg;

   // Register addresses, one copy per protocol engine
   localparam logic [15:0] USBP_ADDR_ENG1 = 16'hC08A;
   localparam logic [15:0] USBP_ADDR_ENG2 = 16'hC0AA;
   localparam int USBP_NUM_ENG = 2;
   localparam int USBP_NUM_PORT = 2;

   // Field positions; port B sits one (or two) above port A
   localparam int USBP_BIT_A_DM = 12;
   localparam int USBP_BIT_A_DP = 13;
   localparam int USBP_BIT_SPD_A = 10;
   localparam int USBP_BIT_HOST = 9;
   localparam int USBP_BIT_RES_A = 7;
   localparam int USBP_BIT_FRC_A = 3;
   localparam int USBP_BIT_SUSP = 2;
   localparam int USBP_BIT_SOF_A = 0;
   localparam int USBP_STATUS_LO = 12;
   localparam int USBP_CTRL_HI = 11;

   localparam logic [15:0] USBP_WR_MASK = 16'h0FFF;
   localparam logic [11:0] USBP_CTRL_RESET = 12'h000;
   localparam logic [15:0] USBP_RD_NONE = 16'h0000;

   typedef enum logic [1:0] {
      USBP_FRC_NORMAL = 2'b00,
      USBP_FRC_J = 2'b01,
      USBP_FRC_SE0 = 2'b10,
      USBP_FRC_K = 2'b11
   } usbp_force_t;

   typedef struct packed {
      logic dp;
      logic dm;
   } usbp_line_t;

   typedef struct packed {
      logic dpOut;
      logic dmOut;
      logic dpOe;
      logic dmOe;
      logic dpPullUp;
      logic dmPullUp;
      logic dpPullDn;
      logic dmPullDn;
   } usbp_pin_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } usbp_bus_t;

endpackage

/* File: verilog/usbp_port_drive.sv */
// Line driver and pull resistor selection for one USB port.
// Assumes control bits come from registers; purely combinational.
`timescale 1ns/10ps
module usbp_port_drive (
   // Control fields
   input wire logic resEn,
   input wire logic hostMode,
   input wire logic lowSpeed,
   input wire usbp_pkg::usbp_force_t force_,
   input wire logic suspend,
   input wire logic active,
   // Engine transmit side
   input wire usbp_pkg::usbp_line_t txLine,
   input wire logic txEn,
   // Pin side
   output usbp_pkg::usbp_pin_t pin
);
   import usbp_pkg::*;

   wire logic jDp;
   wire logic driveTx;
   wire logic forced;

   // J idles D+ high at full speed, D- high at low speed
   assign jDp = !lowSpeed;
   // Forcing works even on an unselected or suspended port (resume K)
   assign forced = (force_ != USBP_FRC_NORMAL);
   assign driveTx = active && txEn && !suspend;

   always_comb begin
      pin = '0;
      case (force_)
         USBP_FRC_SE0: begin
            pin.dpOut = 1'b0;
            pin.dmOut = 1'b0;
         end
         USBP_FRC_J: begin
            pin.dpOut = jDp;
            pin.dmOut = !jDp;
         end
         USBP_FRC_K: begin
            pin.dpOut = !jDp;
            pin.dmOut = jDp;
         end
         default: begin
            pin.dpOut = txLine.dp;
            pin.dmOut = txLine.dm;
         end
      endcase
      pin.dpOe = forced || driveTx;
      pin.dmOe = forced || driveTx;
      // host role pulls both lines down
      pin.dpPullDn = resEn && hostMode;
      pin.dmPullDn = resEn && hostMode;
      // device role, one pull-up by speed
      pin.dpPullUp = resEn && !hostMode && !lowSpeed;
      pin.dmPullUp = resEn && !hostMode && lowSpeed;
   end
endmodule

/* File: verif/usbp_far_end.sv */
// Far-end USB party on all four ports; resolves each line.
// Assumes the bench sets what the far party drives and when.
`timescale 1ns/10ps
module usbp_far_end (
   // Clock
   input wire logic clk_sys,
   // Block pins
   input wire usbp_pkg::usbp_pin_t [3:0] pinOut,
   // Far party drive
   input wire usbp_pkg::usbp_line_t [3:0] farLine,
   input wire logic [3:0] farEn,
   // Resolved levels
   output usbp_pkg::usbp_line_t [3:0] pinIn
);
   import usbp_pkg::*;
   usbp_line_t [3:0] last;
   // Unpulled, undriven line drifts instead of holding
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pinIn[i].dp = pinOut[i].dpOe ? pinOut[i].dpOut :
            farEn[i] ? farLine[i].dp : pinOut[i].dpPullUp ? 1'b1 :
            pinOut[i].dpPullDn ? 1'b0 : ~last[i].dp;
         pinIn[i].dm = pinOut[i].dmOe ? pinOut[i].dmOut :
            farEn[i] ? farLine[i].dm : pinOut[i].dmPullUp ? 1'b1 :
            pinOut[i].dmPullDn ? 1'b0 : ~last[i].dm;
      end
   end
   always @(posedge clk_sys) last <= pinIn;
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the port line control block.
// Assumes the far-end model resolves the pins; reads are scored
// through a queue of expected words.
`timescale 1ns/10ps
module tb;
   import usbp_pkg::*;
   logic clk_sys, arst_n, pend, ls, h, r;
   usbp_bus_t cpuBus, hostPortBus;
   logic [15:0] cpuRdata, hostPortRdata, d;
   logic [1:0] portSel, txEn, hostMode, activeLowSpeed, xcvrPowerDown;
   usbp_line_t [1:0] txLine, rxLine;
   logic [3:0] sofEopEn, farEn, ex;
   usbp_line_t [3:0] pinIn, farLine;
   usbp_pin_t [3:0] pinOut;
   logic [16:0] expQ[$];
   logic [16:0] e;
   logic [15:0] addr[2];
   int numErrors, testsRun, seed;
   usbp_line_ctrl usbp_line_ctrl_i (.clk_sys(clk_sys), .arst_n(arst_n),
      .cpuBus(cpuBus), .cpuRdata(cpuRdata), .hostPortBus(hostPortBus),
      .hostPortRdata(hostPortRdata), .portSel(portSel), .txLine(txLine),
      .txEn(txEn), .rxLine(rxLine), .hostMode(hostMode),
      .activeLowSpeed(activeLowSpeed), .xcvrPowerDown(xcvrPowerDown),
      .sofEopEn(sofEopEn), .pinIn(pinIn), .pinOut(pinOut));
   usbp_far_end usbp_far_end_i (.clk_sys(clk_sys), .pinOut(pinOut),
      .farLine(farLine), .farEn(farEn), .pinIn(pinIn));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      testsRun++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("errors %0d checks %0d", numErrors, testsRun);
      if (numErrors == 0 && testsRun > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One-cycle strobe at falling edges, then one idle cycle so that
   // back-to-back calls never touch a bus twice in one time step
   task automatic acc(input logic hp, rdn, input logic [15:0] a, wd);
      if (hp) hostPortBus = '{rdn, ~rdn, a, wd};
      else cpuBus = '{rdn, ~rdn, a, wd};
      @(negedge clk_sys);
      cpuBus = '0;
      hostPortBus = '0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic hp, input logic [15:0] a, exp);
      expQ.push_back({hp, exp});
      acc(hp, 1'b1, a, 16'h0000);
   endtask
   task automatic wr(input logic [15:0] wd);
      acc(1'b0, 1'b0, addr[0], wd);
   endtask
   always @(posedge clk_sys) pend <= cpuBus.rd | hostPortBus.rd;
   always @(negedge clk_sys) begin
      if (pend) begin
         e = expQ.pop_front();
         chk(e[16] ? hostPortRdata : cpuRdata, e[15:0]);
      end
   end
   initial begin
      #100000;
      numErrors++;
      results();
   end
   initial begin
      seed = 32'h6a55aa55;
      addr = '{USBP_ADDR_ENG1, USBP_ADDR_ENG2};
      {arst_n, cpuBus, hostPortBus, portSel, txLine, txEn} = '0;
      farEn = 4'hF;
      farLine = 8'($random(seed));
      repeat (10) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      rd(0, addr[0], {farLine[1], farLine[0], 12'h000});
      rd(1, addr[1], {farLine[3], farLine[2], 12'h000});
      for (int k = 0; k < 6; k++) begin
         d = 16'($random(seed)) & 16'hFF87;
         // device role keeps frame bits clear
         if (!d[9]) d[1:0] = 2'b00;
         acc(k[0], 1'b0, addr[k / 3], d);
         rd(~k[0], addr[k / 3], {farLine[2 * (k / 3) + 1],
            farLine[2 * (k / 3)], d[11:0]});
      end
      rd(0, 16'hC08C, 16'h0000);
      // same-cycle clash: host port word wins
      cpuBus = '{1'b0, 1'b1, addr[1], 16'h0100};
      hostPortBus = '{1'b0, 1'b1, addr[1], 16'h0A80};
      @(negedge clk_sys);
      {cpuBus, hostPortBus} = '0;
      @(negedge clk_sys);
      rd(0, addr[1], {farLine[3], farLine[2], 12'hA80});
      farEn = 4'h0;
      for (int v = 0; v < 8; v++) begin
         {ls, h, r} = v[2:0];
         wr({4'h0, ls, ls, h, r, r, 7'h00});
         ex = {r & ~h & ~ls, r & ~h & ls, r & h, r & h};
         chk(pinOut[0][3:0], ex);
         chk(pinOut[1][3:0], ex);
         chk({hostMode[0], activeLowSpeed[0]}, {h, ls});
      end
      for (int v = 0; v < 8; v++) begin
         ls = v[2];
         wr({4'h0, ls, 4'h0, v[1:0], 5'h00});
         ex = v[1:0] == 2'd1 ? {~ls, ls, 2'b11} : v[1:0] == 2'd3 ?
            {ls, ~ls, 2'b11} : {2'b00, v[1:0] != 2'd0, v[1:0] != 2'd0};
         chk(pinOut[1][7:4] & (v[1:0] != 0 ? 4'hF : 4'h3), ex);
         chk(pinOut[0][5:4], 2'b00);
      end
      portSel = 2'b01;
      farEn = 4'hF;
      wr(16'h0000);
      @(negedge clk_sys);
      chk(rxLine[0], farLine[1]);
      farEn = 4'h0;
      txLine = 4'($random(seed));
      txEn = 2'b01;
      wr(16'h0000);
      chk(pinOut[1][7:4], {txLine[0], 2'b11});
      chk(pinOut[0][5:4], 2'b00);
      wr(16'h0203);
      chk(sofEopEn[1:0], 2'b10);
      wr(16'h0207);
      @(negedge clk_sys);
      chk({xcvrPowerDown[0], rxLine[0], pinOut[1][5:4]}, 5'h10);
      results();
   end
endmodule
